// File: rtl/vcg_cfg.svh
// Purpose: Constants for the video capture port block
// Assumes: 32-bit Avalon-MM word addressing in bytes
// Notes: Offsets are byte addresses
`ifndef VCG_CFG_SVH
`define VCG_CFG_SVH
`define VCG_PORT_W 24
`define VCG_WIN_WORDS 64
`define VCG_WIN_BASE 12'h000
`define VCG_CTRL_OFS 12'h100
`define VCG_DRV_OFS 12'h104
`define VCG_OUTV_OFS 12'h108
`define VCG_INP_OFS 12'h10c
`define VCG_STAT_OFS 12'h110
`define VCG_LATCH_OFS 12'h114
`define VCG_CTRL_MODE_LSB 0
`define VCG_CTRL_POL_BIT 2
`define VCG_CTRL_RANGE_BIT 3
`define VCG_STAT_INT_BIT 0
`define VCG_STAT_STRAP_BIT 1
`define VCG_LINE_PULSE_CLKS 64
`define VCG_LINE_BIT 23
`define VCG_FIELD_BIT 18
`define VCG_WR_WAIT 2
`define VCG_RD_WAIT 3
`define VCG_CODE_MIN 8'h01
`define VCG_CODE_MAX 8'hfe
`define VCG_Y_LO 8'h10
`define VCG_Y_HI 8'heb
`define VCG_C_HI 8'hf0
`endif

// File: rtl/vcg_pkg.sv
// Purpose: Types for the video capture port block
// Assumes: Nothing beyond the cfg header
// Notes: Mode codes follow the mode field
package vcg_pkg;
    typedef enum logic [1:0] {
        VCG_NORMAL = 2'h0,
        VCG_PIX_IN = 2'h1,
        VCG_PIX_OUT = 2'h2
    } vcg_mode_t;
endpackage : vcg_pkg

// File: rtl/vcg_port.sv
// Purpose: 24-bit general purpose and pixel port with Avalon-MM slave
// Assumes: Pins and port clock sampled by CLK_SYS through three flops
// Notes: Pixel streams are sampled in the system domain
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "vcg_cfg.svh"

// How it works
// - Twenty-four two-way pins, normal, pixel input or pixel output mode.
// - Pixel input samples from pins replace internal decoder output.
// - Pixel output drives decoder stream out, and still passes it on.
// - Interrupt pin rising edge sets a sticky status bit; IRQ follows when ctrl bit 31 is set.
// - Active write strobe latches pins into latch register; polarity set.
// - At reset release, strobe high and interrupt low force pixel output.
// - Forced mode holds until a later reset samples other pin levels.
// - Per-pin drive enable register sets direction in normal mode.
// - Output value bits drive enabled pins in normal mode.
// - Inputs ignore output value; pin levels readable separately.
// - Sixty-four word contiguous window decoded for burst writes.
// - Window writes keep only low twenty-four bits for the pins.
// - Pixel input uses the external port clock for sampling pixels.
// - Pixel output drives the single rate pixel clock on clock pin.
// - Range bit zero limits luma 16..235 and chroma 16..240.
// - Codes 0 and 255 never appear as pixel values.
// - Every accepted bus command takes at least three cycles.
// - Writes run without extra waits beyond the fixed decode cycles.
// - Reads insert no extra wait state; same count as writes.
// - All write kinds alike, all read kinds alike.
// - Bit 23 carries active-low line start pulse, 64 clocks long.
// - Field pin high during even fields, low during odd fields.
module vcg_port
    import vcg_pkg::*;
#(
    parameter int PORT_W = `VCG_PORT_W
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Avalon-MM slave
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Port pins
    input wire logic [PORT_W-1:0] PORT_PIN_I,
    output logic [PORT_W-1:0] PORT_PIN_O,
    output logic [PORT_W-1:0] PORT_PIN_OE,
    input wire logic PORT_CLOCK_PIN_I,
    output logic PORT_CLOCK_PIN_O,
    output logic PORT_CLOCK_PIN_OE,
    input wire logic PORT_INTERRUPT_PIN,
    input wire logic PORT_WRITE_STROBE_PIN,
    // Internal decoder stream
    input wire logic SINGLE_RATE_PIXEL_CLOCK,
    input wire logic [7:0] DEC_LUMA,
    input wire logic [7:0] DEC_CHROMA,
    input wire logic DEC_LINE_START,
    input wire logic DEC_EVEN_FIELD,
    // Stream to the rest of the device
    output logic [7:0] PIX_LUMA,
    output logic [7:0] PIX_CHROMA,
    output logic PIX_VALID,
    // Interrupt
    output logic PORT_IRQ
);

    logic [2:0] s_pin_q [PORT_W];
    logic [2:0] s_clk_q, s_int_q, s_stb_q;
    logic [PORT_W-1:0] pin_f_q;
    logic clk_f_q, int_f_q, stb_f_q, clk_prev_q, int_prev_q;
    logic [1:0] mode_sw_q;
    logic pol_q, range_q, forced_q, strap_pend_q;
    logic [1:0] strap_cnt_q;
    logic [PORT_W-1:0] pin_drive_enable_reg_q;
    logic [PORT_W-1:0] port_output_value_reg_q;
    logic [PORT_W-1:0] inp_q, latch_q;
    logic int_sticky_q, int_mask_q;
    logic [1:0] cnt_q;
    logic [6:0] line_cnt_q;
    logic line_prev_q;
    logic [7:0] luma_q, chroma_q;
    logic valid_q;
    vcg_mode_t mode;
    logic clk_rise, int_rise, stb_act, busy, done, win_hit;
    logic [1:0] wait_n;
    logic [7:0] y_src, c_src;

    // Three-flop synchronisers
    // Strobe and interrupt idle high on pull-ups; low would fake an edge
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_clk_q <= 3'h0;
            s_int_q <= 3'h7;
            s_stb_q <= 3'h7;
        end else begin
            s_clk_q <= {s_clk_q[1:0], PORT_CLOCK_PIN_I};
            s_int_q <= {s_int_q[1:0], PORT_INTERRUPT_PIN};
            s_stb_q <= {s_stb_q[1:0], PORT_WRITE_STROBE_PIN};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    s_pin_q[gi] <= 3'h0;
                    pin_f_q[gi] <= 1'b0;
                end else begin
                    s_pin_q[gi] <= {s_pin_q[gi][1:0], PORT_PIN_I[gi]};
                    if (s_pin_q[gi][1] == s_pin_q[gi][2])
                        pin_f_q[gi] <= s_pin_q[gi][2];
                end
            end
        end
    endgenerate

    // Filtered levels change once stages two and three agree
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            clk_f_q <= 1'b0;
            int_f_q <= 1'b1;
            stb_f_q <= 1'b1;
            clk_prev_q <= 1'b0;
            int_prev_q <= 1'b1;
        end else begin
            if (s_clk_q[1] == s_clk_q[2])
                clk_f_q <= s_clk_q[2];
            if (s_int_q[1] == s_int_q[2])
                int_f_q <= s_int_q[2];
            if (s_stb_q[1] == s_stb_q[2])
                stb_f_q <= s_stb_q[2];
            clk_prev_q <= clk_f_q;
            int_prev_q <= int_f_q;
        end
    end

    assign clk_rise = clk_f_q && !clk_prev_q;
    assign int_rise = int_f_q && !int_prev_q;
    assign stb_act = (stb_f_q == pol_q);

    // Strap sampled once the synchronisers hold real pin levels
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            forced_q <= 1'b0;
            strap_pend_q <= 1'b1;
            strap_cnt_q <= 2'h0;
        end else begin
            if (strap_cnt_q != 2'h3)
                strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_pend_q && strap_cnt_q == 2'h3 &&
                s_stb_q[2] == s_stb_q[1] && s_int_q[2] == s_int_q[1]) begin
                strap_pend_q <= 1'b0;
                forced_q <= s_stb_q[2] && !s_int_q[2];
            end
        end
    end

    always_comb begin
        if (forced_q)
            mode = VCG_PIX_OUT;
        else if (mode_sw_q == 2'h1)
            mode = VCG_PIX_IN;
        else if (mode_sw_q == 2'h2)
            mode = VCG_PIX_OUT;
        else
            mode = VCG_NORMAL;
    end

    // Window of sixty-four words at base
    assign win_hit = AVS_ADDRESS < 12'(`VCG_WIN_BASE + 4 * `VCG_WIN_WORDS);

    // Fixed decode cycles; same count on reads
    // No distinction among write or read flavours
    assign wait_n = AVS_READ ? 2'(`VCG_RD_WAIT - 1) : 2'(`VCG_WR_WAIT);
    assign busy = AVS_READ || AVS_WRITE;
    assign done = busy && (cnt_q == wait_n);
    assign AVS_WAITREQUEST = busy && !done;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            cnt_q <= 2'h0;
        else if (!busy || done)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_q + 2'h1;
    end

    // Register writes take effect on the completing edge
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_sw_q <= 2'h0;
            pol_q <= 1'b1;
            range_q <= 1'b0;
            pin_drive_enable_reg_q <= '0;
            port_output_value_reg_q <= '0;
            int_mask_q <= 1'b0;
        end else if (done && AVS_WRITE) begin
            // Window write keeps low 24 bits only
            // Each burst word lands without extra stalls
            if (win_hit && mode == VCG_NORMAL)
                port_output_value_reg_q <= AVS_WRITEDATA[PORT_W-1:0];
            else if (AVS_ADDRESS == `VCG_CTRL_OFS) begin
                mode_sw_q <= AVS_WRITEDATA[`VCG_CTRL_MODE_LSB +: 2];
                pol_q <= AVS_WRITEDATA[`VCG_CTRL_POL_BIT];
                range_q <= AVS_WRITEDATA[`VCG_CTRL_RANGE_BIT];
                int_mask_q <= AVS_WRITEDATA[31];
            end else if (AVS_ADDRESS == `VCG_DRV_OFS)
                pin_drive_enable_reg_q <= AVS_WRITEDATA[PORT_W-1:0];
            else if (AVS_ADDRESS == `VCG_OUTV_OFS)
                port_output_value_reg_q <= AVS_WRITEDATA[PORT_W-1:0];
        end
    end

    // Sticky interrupt, set wins over write-one clear
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            int_sticky_q <= 1'b0;
        else if (int_rise)
            int_sticky_q <= 1'b1;
        else if (done && AVS_WRITE && AVS_ADDRESS == `VCG_STAT_OFS &&
                 AVS_WRITEDATA[`VCG_STAT_INT_BIT])
            int_sticky_q <= 1'b0;
    end
    assign PORT_IRQ = int_sticky_q && int_mask_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            latch_q <= '0;
            inp_q <= '0;
        end else begin
            inp_q <= pin_f_q;
            if (stb_act)
                latch_q <= pin_f_q;
        end
    end

    // Read data loaded one edge early so it stands at the completing edge
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            AVS_READDATA <= 32'h0;
        else if (AVS_READ && !done && cnt_q == wait_n - 2'h1) begin
            if (win_hit)
                AVS_READDATA <= 32'(port_output_value_reg_q);
            else
                case (AVS_ADDRESS)
                    `VCG_CTRL_OFS: AVS_READDATA <= {int_mask_q, 27'h0,
                        range_q, pol_q, mode_sw_q};
                    `VCG_DRV_OFS: AVS_READDATA <= 32'(pin_drive_enable_reg_q);
                    `VCG_OUTV_OFS:
                        AVS_READDATA <= 32'(port_output_value_reg_q);
                    `VCG_INP_OFS: AVS_READDATA <= 32'(inp_q);
                    `VCG_STAT_OFS: AVS_READDATA <= {30'h0, forced_q,
                        int_sticky_q};
                    `VCG_LATCH_OFS: AVS_READDATA <= 32'(latch_q);
                    default: AVS_READDATA <= 32'h0;
                endcase
        end
    end

    // Range clamp; keep 0 and 255 out
    function automatic logic [7:0] vcg_clip(input logic [7:0] v,
                                            input logic [7:0] hi,
                                            input logic lim);
        logic [7:0] r;
        r = v;
        if (lim && r < `VCG_Y_LO)
            r = `VCG_Y_LO;
        else if (lim && r > hi)
            r = hi;
        if (r < `VCG_CODE_MIN)
            r = `VCG_CODE_MIN;
        else if (r > `VCG_CODE_MAX)
            r = `VCG_CODE_MAX;
        return r;
    endfunction : vcg_clip

    assign y_src = (mode == VCG_PIX_IN) ? pin_f_q[15:8] : DEC_LUMA;
    assign c_src = (mode == VCG_PIX_IN) ? pin_f_q[7:0] : DEC_CHROMA;

    // Pixel input taken on port clock rising edges
    // Decoder stream keeps flowing in every other mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            luma_q <= 8'h10;
            chroma_q <= 8'h80;
            valid_q <= 1'b0;
        end else begin
            valid_q <= (mode == VCG_PIX_IN) ? clk_rise : 1'b1;
            if (mode != VCG_PIX_IN || clk_rise) begin
                luma_q <= vcg_clip(y_src, `VCG_Y_HI, !range_q);
                chroma_q <= vcg_clip(c_src, `VCG_C_HI, !range_q);
            end
        end
    end
    assign PIX_LUMA = luma_q;
    assign PIX_CHROMA = chroma_q;
    assign PIX_VALID = valid_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            line_cnt_q <= 7'h0;
            line_prev_q <= 1'b0;
        end else begin
            line_prev_q <= DEC_LINE_START;
            if (DEC_LINE_START && !line_prev_q)
                line_cnt_q <= 7'(`VCG_LINE_PULSE_CLKS);
            else if (line_cnt_q != 7'h0)
                line_cnt_q <= line_cnt_q - 7'h1;
        end
    end

    always_comb begin
        PORT_PIN_O = '0;
        PORT_PIN_OE = '0;
        case (mode)
            VCG_NORMAL: begin
                PORT_PIN_OE = pin_drive_enable_reg_q;
                PORT_PIN_O = port_output_value_reg_q;
            end
            VCG_PIX_OUT: begin
                PORT_PIN_OE = '1;
                PORT_PIN_O[15:8] = luma_q;
                PORT_PIN_O[7:0] = chroma_q;
                PORT_PIN_O[`VCG_LINE_BIT] = (line_cnt_q == 7'h0);
                PORT_PIN_O[`VCG_FIELD_BIT] = DEC_EVEN_FIELD;
            end
            default: begin
                PORT_PIN_OE = '0;
            end
        endcase
    end

    // Pixel clock driven out in output mode
    assign PORT_CLOCK_PIN_O = (mode == VCG_PIX_OUT) && SINGLE_RATE_PIXEL_CLOCK;
    assign PORT_CLOCK_PIN_OE = (mode == VCG_PIX_OUT);

endmodule : vcg_port

// File: sim/vcg_port_properties.sv
// Purpose: Port-level checker for vcg_port
// Assumes: Bus answer on the third edge of a request
// Notes: Sees only top ports; bound from the bench top
`timescale 1ns/1ps
module vcg_port_properties #(
    parameter int PORT_W = 24
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Bus
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Pins and stream
    input wire logic [PORT_W-1:0] PORT_PIN_O,
    input wire logic [PORT_W-1:0] PORT_PIN_OE,
    input wire logic PORT_CLOCK_PIN_O,
    input wire logic PORT_CLOCK_PIN_OE,
    input wire logic SINGLE_RATE_PIXEL_CLOCK,
    input wire logic DEC_EVEN_FIELD,
    input wire logic [7:0] PIX_LUMA,
    input wire logic [7:0] PIX_CHROMA,
    input wire logic PIX_VALID
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [6:0] low_q;
    // Counts only from a seen falling edge, so a partial pulse is ignored
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            low_q <= 7'h00;
        end else if (!PORT_CLOCK_PIN_OE || PORT_PIN_O[23]) begin
            low_q <= 7'h00;
        end else if ($fell(PORT_PIN_O[23]) || low_q != 7'h00) begin
            low_q <= low_q + 7'h01;
        end
    end
    sequence s_req;
        $rose(AVS_READ || AVS_WRITE);
    endsequence
    sequence s_answer;
        AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST;
    endsequence
    wait_len_a: assert property (s_req |-> s_answer)
        else $error("bus answer not on third edge");
    idle_wait_a: assert property (
        !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("waitrequest high while idle");
    rdata_hold_a: assert property (
        $changed(AVS_READDATA) |-> $past(AVS_READ))
        else $error("read data changed without a read");
    clk_out_a: assert property (
        PORT_CLOCK_PIN_OE |-> PORT_CLOCK_PIN_O == SINGLE_RATE_PIXEL_CLOCK)
        else $error("port clock pin not pixel clock");
    pin_drive_a: assert property (
        PORT_CLOCK_PIN_OE |-> &PORT_PIN_OE[15:0] && PORT_PIN_OE[23]
        && PORT_PIN_OE[18])
        else $error("stream pins not driven in output mode");
    line_pulse_a: assert property (
        PORT_CLOCK_PIN_OE && $rose(PORT_PIN_O[23]) && low_q != 7'h00
        |-> low_q == 7'h40)
        else $error("line start pulse not 64 clocks");
    field_pin_a: assert property (
        PORT_CLOCK_PIN_OE && $changed(DEC_EVEN_FIELD)
        |-> ##[0:4] PORT_PIN_O[18] == DEC_EVEN_FIELD)
        else $error("field pin does not follow field");
    code_range_a: assert property (
        PIX_VALID |-> PIX_LUMA != 8'h00 && PIX_LUMA != 8'hff
        && PIX_CHROMA != 8'h00 && PIX_CHROMA != 8'hff)
        else $error("reserved code in pixel stream");
endmodule : vcg_port_properties

// File: sim/vcg_ext_dev.sv
// Purpose: Far-side video source and peripheral model
// Assumes: Pull-ups keep strobe and interrupt high
// Notes: Bench moves pins through hierarchical writes
`timescale 1ns/1ps
module vcg_ext_dev (
    // Lines driven from the far side
    output logic [23:0] pin_q,
    output logic pclk_q,
    output logic stb_q,
    output logic int_q
);
    logic run_q;
    initial begin
        pin_q = 24'h000000;
        pclk_q = 1'b0;
        stb_q = 1'b1;
        int_q = 1'b1;
        run_q = 1'b0;
    end
    always #160 pclk_q = run_q ? ~pclk_q : 1'b0;
endmodule : vcg_ext_dev

// File: sim/tb.sv
// Purpose: Self-checking bench for vcg_port
// Assumes: Bus answer after three edges, read data kept until next read
// Notes: Decoder stream runs free from the bench
`timescale 1ns/1ps
`include "vcg_cfg.svh"
bind vcg_port vcg_port_properties #(.PORT_W(PORT_W))
    i_vcg_port_properties (.CLK_SYS, .RST_N, .AVS_READ, .AVS_WRITE,
    .AVS_READDATA, .AVS_WAITREQUEST, .PORT_PIN_O, .PORT_PIN_OE,
    .PORT_CLOCK_PIN_O, .PORT_CLOCK_PIN_OE, .SINGLE_RATE_PIXEL_CLOCK,
    .DEC_EVEN_FIELD, .PIX_LUMA, .PIX_CHROMA, .PIX_VALID);
module tb;
    logic clk_sys, rst_n, rd, wr, srpc, line_st, even;
    logic [11:0] adr;
    logic [31:0] wdat;
    logic [7:0] luma, chroma;
    logic [9:0] cnt;
    wire logic [31:0] rdat;
    wire logic wreq, pclk_o, pclk_oe, ext_clk, pclk, stb, intp, pv, irq;
    wire logic [23:0] pin_o, pin_oe, ext, pin;
    wire logic [7:0] pl, pc;
    int err_count, compares;
    vcg_ext_dev i_vcg_ext_dev (.pin_q(ext), .pclk_q(ext_clk),
        .stb_q(stb), .int_q(intp));
    vcg_port #(.PORT_W(24)) i_vcg_port (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .PORT_PIN_I(pin), .PORT_PIN_O(pin_o),
        .PORT_PIN_OE(pin_oe), .PORT_CLOCK_PIN_I(pclk),
        .PORT_CLOCK_PIN_O(pclk_o), .PORT_CLOCK_PIN_OE(pclk_oe),
        .PORT_INTERRUPT_PIN(intp), .PORT_WRITE_STROBE_PIN(stb),
        .SINGLE_RATE_PIXEL_CLOCK(srpc), .DEC_LUMA(luma),
        .DEC_CHROMA(chroma), .DEC_LINE_START(line_st),
        .DEC_EVEN_FIELD(even), .PIX_LUMA(pl), .PIX_CHROMA(pc),
        .PIX_VALID(pv), .PORT_IRQ(irq));
    // Far side lets go wherever the block drives
    assign pin = (pin_oe & pin_o) | (~pin_oe & ext);
    assign pclk = pclk_oe ? pclk_o : ext_clk;
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cnt <= cnt + 10'h001;
        srpc <= ~srpc;
        line_st <= cnt[7:0] < 8'h08;
        even <= cnt[9];
    end
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wreq !== 1'b0);
        // Read data taken at the edge that ends the wait
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        // Let the completing edge settle before callers look at pins
        @(negedge clk_sys);
        chk("bus latency", 32'h3, n);
    endtask : bus
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr32
    task automatic rdc(input string nm, input logic [11:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rdc
    task automatic reset_dut(input logic s, input logic i);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        i_vcg_ext_dev.stb_q <= s;
        i_vcg_ext_dev.int_q <= i;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : reset_dut
    task automatic t_regs;
        rdc("ctrl", `VCG_CTRL_OFS, 32'h4);
        wr32(`VCG_STAT_OFS, 32'h1);
        rdc("stat", `VCG_STAT_OFS, 32'h0);
        wr32(12'h200, 32'hffffffff);
        rdc("unmapped", 12'h200, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_gpio;
        @(posedge clk_sys) i_vcg_ext_dev.pin_q <= 24'h5a5a5a;
        wr32(`VCG_DRV_OFS, 32'hff00ff00);
        wr32(`VCG_OUTV_OFS, 32'h00a5a5a5);
        chk("drive enable", 32'h00ff00, pin_oe);
        chk("pins", 32'h5aa55a, pin);
        repeat (8) @(posedge clk_sys);
        rdc("input reg", `VCG_INP_OFS, 32'h5aa55a);
        for (int k = 0; k < 64; k++) begin
            wr32(12'(k * 4), 32'hc3000000 | k);
            chk("window", k, pin_o);
        end
        rdc("window read", 12'h0fc, 32'h3f);
        $display("t_gpio done");
    endtask : t_gpio
    task automatic t_strobe;
        wr32(`VCG_DRV_OFS, 32'h0);
        @(posedge clk_sys) i_vcg_ext_dev.pin_q <= 24'h123456;
        repeat (8) @(posedge clk_sys);
        rdc("latch high", `VCG_LATCH_OFS, 32'h123456);
        wr32(`VCG_CTRL_OFS, 32'h0);
        @(posedge clk_sys) i_vcg_ext_dev.pin_q <= 24'h654321;
        repeat (8) @(posedge clk_sys);
        rdc("latch held", `VCG_LATCH_OFS, 32'h123456);
        @(posedge clk_sys) i_vcg_ext_dev.stb_q <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdc("latch low", `VCG_LATCH_OFS, 32'h654321);
        @(posedge clk_sys) i_vcg_ext_dev.stb_q <= 1'b1;
        $display("t_strobe done");
    endtask : t_strobe
    task automatic t_irq;
        @(posedge clk_sys) i_vcg_ext_dev.int_q <= 1'b0;
        repeat (6) @(posedge clk_sys);
        i_vcg_ext_dev.int_q <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("irq masked", 32'h0, irq);
        rdc("stat set", `VCG_STAT_OFS, 32'h1);
        wr32(`VCG_CTRL_OFS, 32'h80000000);
        chk("irq", 32'h1, irq);
        wr32(`VCG_STAT_OFS, 32'h1);
        chk("irq cleared", 32'h0, irq);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_pixin;
        logic [31:0] cfg [3] = '{32'h1, 32'h1, 32'h9};
        logic [15:0] inp [3] = '{16'h5566, 16'h00ff, 16'h00ff};
        logic [15:0] exp [3] = '{16'h5566, 16'h10f0, 16'h01fe};
        @(posedge clk_sys) i_vcg_ext_dev.run_q <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr32(`VCG_CTRL_OFS, cfg[k]);
            @(posedge clk_sys) i_vcg_ext_dev.pin_q <= {8'h00, inp[k]};
            repeat (3) @(posedge pv);
            @(negedge clk_sys);
            chk("pixel in", exp[k], {pl, pc});
        end
        @(posedge clk_sys) i_vcg_ext_dev.run_q <= 1'b0;
        $display("t_pixin done");
    endtask : t_pixin
    task automatic t_pixout;
        @(posedge clk_sys) luma <= 8'h42;
        wr32(`VCG_CTRL_OFS, 32'h2);
        repeat (600) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("clock drive", 32'h1, pclk_oe);
        chk("pin stream", {luma, chroma}, pin_o[15:0]);
        chk("inner stream", {luma, chroma}, {pl, pc});
        wr32(`VCG_CTRL_OFS, 32'h0);
        $display("t_pixout done");
    endtask : t_pixout
    task automatic t_strap;
        reset_dut(1'b1, 1'b0);
        rdc("strap", `VCG_STAT_OFS, 32'h2);
        wr32(`VCG_CTRL_OFS, 32'h0);
        chk("forced mode", 32'h1, pclk_oe);
        reset_dut(1'b1, 1'b1);
        wr32(`VCG_STAT_OFS, 32'h1);
        rdc("strap gone", `VCG_STAT_OFS, 32'h0);
        chk("soft mode", 32'h0, pclk_oe);
        $display("t_strap done");
    endtask : t_strap
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #800000;
        err_count++;
        stop_test;
    end
    initial begin
        {rst_n, rd, wr, srpc, line_st, even} = 6'h00;
        {adr, wdat, cnt} = 54'h0;
        luma = 8'h30;
        chroma = 8'h81;
        err_count = 0;
        compares = 0;
        reset_dut(1'b1, 1'b1);
        t_regs;
        t_gpio;
        t_strobe;
        t_irq;
        t_pixin;
        t_pixout;
        t_strap;
        stop_test;
    end
endmodule : tb
